// [rtl/ccp_consts.svh]
// Constants of the CPU to CAN register port: SFR addresses, fields,
// reset values and DMA figures.
// Assumes inclusion by bare name from the package and ccp_port.
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define CCP_SFR_STA 8'hD8
`define CCP_SFR_CON 8'hD9
`define CCP_SFR_DAT 8'hDA
`define CCP_SFR_ADR 8'hDB
`define CCP_BIT_STA_HI 8'hDF
`define CCP_ADR_RESET 8'h64
`define CCP_ADR_DMA 7
`define CCP_ADR_AUTO 5
`define CCP_ADR_FIELD_ONES 5'h1F
`define CCP_CON_RD_PAD 3'h7
`define CCP_TXBUF_BASE 5'h0A
`define CCP_RXBUF_BASE 5'h14
`define CCP_RXBUF_LAST 5'h1D
`define CCP_DESC_BYTES 4'h2
`define CCP_DLC_MAX 4'h8
`define CCP_BYTES_PER_ICYC 4'h4
`define CCP_ICYC_CLKS 4'h3
`endif

// [rtl/ccp_pkg.sv]
// Types of the CPU to CAN register port.
// Assumes ccp_consts.svh is on the include path.
`include "ccp_consts.svh"
package ccp_pkg;
  // One controller register access
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic we;
  } ccp_creq_t;
  // One DMA byte travelling through the buffer
  typedef struct packed {
    logic [7:0] ram_addr;
    logic [4:0] can_addr;
    logic [7:0] data;
  } ccp_dbyte_t;
  // DMA engine states, Gray along the path
  typedef enum logic [1:0] {
    CCP_IDLE = 2'b00,
    CCP_DLC = 2'b01,
    CCP_MOVE = 2'b11,
    CCP_DRAIN = 2'b10
  } ccp_state_t;
endpackage

// [rtl/ccp_port.sv]
// CPU SFR port onto the CAN controller, with background DMA.
// Assumes the CPU SFR bus and the controller/RAM ports share clk_sys_i;
// controller and RAM answer reads combinationally in the same cycle.
`timescale 1ns/10ps
`include "ccp_consts.svh"
module ccp_port
  import ccp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // CPU SFR bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // CPU bit access on bit-addressable space
  input wire logic [7:0] sfr_bit_addr_i,
  input wire logic sfr_bit_rd_i,
  output logic sfr_bit_rdata_o,
  // CAN controller internal register port
  output logic [4:0] can_addr_o,
  output logic can_rd_o,
  output logic can_wr_o,
  output logic [7:0] can_wdata_o,
  input wire logic [7:0] can_rdata_i,
  input wire logic [4:0] can_irq_flags_i,
  output logic can_cmd_wr_o,
  output logic [7:0] can_cmd_o,
  input wire logic [7:0] can_status_i,
  input wire logic can_reset_request_i,
  // Internal data RAM port
  output logic [7:0] ram_addr_o,
  output logic ram_rd_o,
  output logic ram_wr_o,
  output logic [7:0] ram_wdata_o,
  input wire logic [7:0] ram_rdata_i,
  // Controller write stall for DMA bytes
  input wire logic can_ready_i,
  // Interrupt hold-off to the CPU interrupt system
  output logic irq_block_o,
  output logic dma_busy_o
);
  // ==========================================================
  // Reset release
  // Assert at once, release after two edges so no flop sees a runt
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================
  // Functions
  function automatic logic [4:0] inc5(input logic [4:0] a);
    inc5 = a + 5'h01;
  endfunction
  function automatic logic [3:0] clip_dlc(input logic [7:0] d);
    clip_dlc = (d[3:0] > `CCP_DLC_MAX) ? `CCP_DLC_MAX : d[3:0];
  endfunction
  // RX length from the chosen buffer address to the end of the message;
  // a start past the last data byte moves nothing instead of wrapping
  function automatic logic [3:0] rx_len(input logic [7:0] d,
      input logic [4:0] a);
    logic [4:0] stop;
    stop = 5'(clip_dlc(d)) + 5'(`CCP_DESC_BYTES) + `CCP_RXBUF_BASE;
    rx_len = (a < stop) ? 4'(stop - a) : 4'h0;
  endfunction

  // ==========================================================
  // Registers and decode
  logic [7:0] can_address_pointer;
  logic [7:0] dma_ram_start_address;
  ccp_state_t state;
  ccp_state_t next_state;
  wire sel_sta = (sfr_addr_i == `CCP_SFR_STA);
  wire sel_con = (sfr_addr_i == `CCP_SFR_CON);
  wire sel_dat = (sfr_addr_i == `CCP_SFR_DAT);
  wire sel_adr = (sfr_addr_i == `CCP_SFR_ADR);
  wire dat_acc = sel_dat && (sfr_rd_i || sfr_wr_i);
  wire auto_increment_enable = can_address_pointer[`CCP_ADR_AUTO];
  wire [4:0] reg_field = can_address_pointer[4:0];
  wire dma_start = sfr_wr_i && sel_adr && sfr_wdata_i[`CCP_ADR_DMA]
    && !can_reset_request_i;
  wire is_tx = (can_address_pointer[4:0] == `CCP_TXBUF_BASE);
  wire idle = (state == CCP_IDLE);

  // Read data mux
  // Unmapped addresses read as zero
  wire [7:0] con_rd = {`CCP_CON_RD_PAD, can_irq_flags_i};
  always_comb begin
    if (sel_dat) begin
      sfr_rdata_o = can_rdata_i;
    end else if (sel_con) begin
      sfr_rdata_o = con_rd;
    end else if (sel_sta) begin
      sfr_rdata_o = can_status_i;
    end else if (sel_adr) begin
      sfr_rdata_o = can_address_pointer;
    end else begin
      sfr_rdata_o = 8'h00;
    end
  end
  // Bit read of the status register
  wire bit_hit = (sfr_bit_addr_i[7:3] == 5'(`CCP_SFR_STA >> 3))
    && sfr_bit_rd_i;
  assign sfr_bit_rdata_o = bit_hit
    && can_status_i[sfr_bit_addr_i[2:0]];

  // Command pass-through
  assign can_cmd_wr_o = sfr_wr_i && sel_con && idle;
  assign can_cmd_o = sfr_wdata_i;

  // ==========================================================
  // DMA engine
  // Fetch side reads one byte a clock into the two-entry buffer; the
  // drain side writes it to the controller (TX) or RAM (RX), so a
  // stalled controller holds bytes back instead of losing them.
  // Window and command accesses are ignored while a transfer runs.
  logic [7:0] ram_ptr;
  logic [4:0] can_ptr;
  logic [3:0] left;
  logic [1:0] icyc;
  logic [2:0] burst;
  ccp_dbyte_t buf_in;
  ccp_dbyte_t buf_out;
  logic buf_iv;
  logic buf_ir;
  logic buf_ov;
  logic buf_or;
  wire tick = (icyc == 2'h0);
  wire can_fetch = (burst != 3'h0) || tick;
  // Length code source: RAM for TX, receive descriptor for RX
  wire [7:0] dlc_byte = is_tx ? ram_rdata_i : can_rdata_i;
  // Whole TX message, or RX tail from the chosen buffer address
  wire [3:0] tx_total = clip_dlc(dlc_byte) + `CCP_DESC_BYTES;
  wire [3:0] rx_total = rx_len(dlc_byte, reg_field);
  wire [3:0] total = is_tx ? tx_total : rx_total;
  wire fetch = (state == CCP_MOVE) && (left != 4'h0)
    && buf_ir && can_fetch;
  assign buf_iv = fetch;
  assign buf_in = '{ram_addr: ram_ptr, can_addr: can_ptr,
    data: is_tx ? ram_rdata_i : can_rdata_i};
  assign buf_or = is_tx ? can_ready_i : 1'b1;

  ccp_skid u_skid (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .flush_i(can_reset_request_i),
    .in_valid_i(buf_iv),
    .in_ready_o(buf_ir),
    .in_data_i(buf_in),
    .out_valid_o(buf_ov),
    .out_ready_i(buf_or),
    .out_data_o(buf_out)
  );

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      CCP_IDLE: begin
        if (dma_start) begin
          next_state = CCP_DLC;
        end
      end
      CCP_DLC: begin
        next_state = CCP_MOVE;
      end
      CCP_MOVE: begin
        if (left == 4'h0) begin
          next_state = CCP_DRAIN;
        end
      end
      default: begin
        if (!buf_ov) begin
          next_state = CCP_IDLE;
        end
      end
    endcase
    if (can_reset_request_i) begin
      next_state = CCP_IDLE;
    end
  end

  // State and counters
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= CCP_IDLE;
      ram_ptr <= 8'h00;
      can_ptr <= 5'h00;
      left <= 4'h0;
      icyc <= 2'h0;
      burst <= 3'h0;
    end else begin
      state <= next_state;
      icyc <= tick ? 2'(`CCP_ICYC_CLKS) : icyc - 2'h1;
      if (tick) begin
        burst <= 3'(`CCP_BYTES_PER_ICYC) - {2'h0, fetch};
      end else if (fetch) begin
        burst <= burst - 3'h1;
      end
      if (state == CCP_IDLE) begin
        ram_ptr <= dma_ram_start_address;
        can_ptr <= reg_field;
      end else if (state == CCP_DLC) begin
        // Pointer holds the new buffer address only from here on
        ram_ptr <= dma_ram_start_address;
        can_ptr <= reg_field;
        left <= total;
      end else if (fetch) begin
        ram_ptr <= ram_ptr + 8'h01;
        can_ptr <= inc5(can_ptr);
        left <= left - 4'h1;
      end
    end
  end

  // DMA length code lookup address: TX at RAM+1, RX at descriptor 2
  wire dlc_phase = (state == CCP_DLC);
  wire [7:0] dlc_ram_addr = dma_ram_start_address + 8'h01;
  wire [4:0] dlc_can_addr = `CCP_RXBUF_BASE + 5'h01;

  // ==========================================================
  // Pointer and RAM start register
  // A pointer write without the DMA bit, or one refused under reset
  // request, leaves the DMA bit low so reads never show a false start
  wire [4:0] next_field = inc5(reg_field);
  wire wrap = (reg_field == `CCP_ADR_FIELD_ONES);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      can_address_pointer <= `CCP_ADR_RESET;
      dma_ram_start_address <= 8'h00;
    end else begin
      if (sfr_wr_i && sel_sta && idle) begin
        dma_ram_start_address <= sfr_wdata_i;
      end
      if (sfr_wr_i && sel_adr && idle) begin
        can_address_pointer <= sfr_wdata_i;
        if (!dma_start) begin
          can_address_pointer[`CCP_ADR_DMA] <= 1'b0;
        end
      end else if (dat_acc && idle && auto_increment_enable) begin
        can_address_pointer[4:0] <= next_field;
        if (wrap) begin
          can_address_pointer[`CCP_ADR_AUTO] <= 1'b0;
        end
      end else if (state == CCP_DRAIN && !buf_ov) begin
        can_address_pointer[`CCP_ADR_DMA] <= 1'b0;
      end else if (can_reset_request_i) begin
        can_address_pointer[`CCP_ADR_DMA] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Controller and RAM port drive
  wire dma_on = !idle;
  wire rx_wr = buf_ov && !is_tx;
  wire tx_wr = buf_ov && is_tx;
  assign can_addr_o = dlc_phase ? (is_tx ? reg_field : dlc_can_addr)
    : tx_wr ? buf_out.can_addr : fetch ? can_ptr : reg_field;
  assign can_rd_o = dma_on ? (!is_tx && (fetch || dlc_phase))
    : (sfr_rd_i && sel_dat);
  assign can_wr_o = dma_on ? tx_wr : (sfr_wr_i && sel_dat);
  assign can_wdata_o = dma_on ? buf_out.data : sfr_wdata_i;
  assign ram_addr_o = dlc_phase ? dlc_ram_addr
    : rx_wr ? buf_out.ram_addr : ram_ptr;
  assign ram_rd_o = is_tx && (fetch || dlc_phase);
  assign ram_wr_o = rx_wr;
  assign ram_wdata_o = buf_out.data;
  assign irq_block_o = dma_on;
  assign dma_busy_o = dma_on;
endmodule // ccp_port

// [rtl/ccp_skid.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/10ps
module ccp_skid
  import ccp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire ccp_dbyte_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output ccp_dbyte_t out_data_o
);
  // ==========================================================
  // Storage
  ccp_dbyte_t mem [2];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // Handshake views
  assign in_ready_o = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o = mem[rp];
  // Pointers and count
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else if (flush_i) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp <= wp ^ push;
      rp <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  // Data entries
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
endmodule // ccp_skid

// [tb/ccp_partner.sv]
// Model of the controller register file and the internal RAM.
// Assumes same-cycle reads and one clock.
`timescale 1ns/10ps
module ccp_partner (
  input wire logic clk_sys_i, can_rd_i, can_wr_i, can_ready_i,
  input wire logic can_cmd_wr_i, ram_rd_i, ram_wr_i,
  input wire logic [4:0] can_addr_i,
  input wire logic [7:0] can_wdata_i, can_cmd_i, ram_addr_i, ram_wdata_i,
  output logic [7:0] can_rdata_o,
  output logic [7:0] ram_rdata_o
);
  // ==========
  // Storage with known contents
  logic [7:0] regs [32];
  logic [7:0] mem [256];
  logic [7:0] cmd;
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 8'hA0 + 8'(i);
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    cmd = 8'h00;
  end
  // Unselected reads show the inverse, never the real byte
  assign can_rdata_o = can_rd_i ? regs[can_addr_i] : ~regs[can_addr_i];
  assign ram_rdata_o = ram_rd_i ? mem[ram_addr_i] : ~mem[ram_addr_i];
  // Writes land on the edge; the register file waits on ready
  always @(posedge clk_sys_i) begin
    if (can_wr_i && can_ready_i) regs[can_addr_i] <= can_wdata_i;
    if (ram_wr_i) mem[ram_addr_i] <= ram_wdata_i;
    if (can_cmd_wr_i) cmd <= can_cmd_i;
  end
endmodule // ccp_partner

// [tb/ccp_port_chk.sv]
// Checker for ccp_port, bound at the foot of this file.
// Assumes the single clock and active-low reset of the port.
`timescale 1ns/10ps
module ccp_port_chk (
  input wire logic clk_sys_i, nrst_i, sfr_rd_i, sfr_wr_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
  input wire logic [7:0] sfr_bit_addr_i, can_status_i, can_cmd_o,
  input wire logic [7:0] can_wdata_o,
  input wire logic [4:0] can_irq_flags_i,
  input wire logic sfr_bit_rd_i, sfr_bit_rdata_o, can_cmd_wr_o,
  input wire logic can_wr_o, can_reset_request_i, can_ready_i,
  input wire logic irq_block_o, dma_busy_o, ram_wr_o
);
  // ==========
  // Transfer length, and whether the buffer was ever stalled
  logic [5:0] busy_cnt;
  logic stalled;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt <= 6'h00;
      stalled <= 1'b0;
    end else begin
      busy_cnt <= dma_busy_o ? busy_cnt + 6'h01 : 6'h00;
      stalled <= dma_busy_o & (stalled | ~can_ready_i);
    end
  end
  // ==========
  // Properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence dma_start;
    sfr_wr_i && sfr_addr_i == 8'hDB && sfr_wdata_i == 8'h8A &&
      !dma_busy_o && !can_reset_request_i;
  endsequence
  chk_win_fwd: assert property (
    sfr_wr_i && sfr_addr_i == 8'hDA && !dma_busy_o
    |-> can_wr_o && can_wdata_o == sfr_wdata_i)
    else $error("window write not forwarded");
  chk_irq_pad: assert property (
    sfr_rd_i && sfr_addr_i == 8'hD9
    |-> sfr_rdata_o == {3'h7, can_irq_flags_i})
    else $error("flag read wrong");
  chk_cmd_fwd: assert property (
    sfr_wr_i && sfr_addr_i == 8'hD9 && !dma_busy_o
    |-> can_cmd_wr_o && can_cmd_o == sfr_wdata_i)
    else $error("command not forwarded");
  chk_sta_read: assert property (
    sfr_rd_i && sfr_addr_i == 8'hD8 |-> sfr_rdata_o == can_status_i)
    else $error("status read wrong");
  chk_bit_read: assert property (
    sfr_bit_rd_i && sfr_bit_addr_i[7:3] == 5'h1B
    |-> sfr_bit_rdata_o == can_status_i[sfr_bit_addr_i[2:0]])
    else $error("status bit read wrong");
  chk_dma_time: assert property (
    dma_busy_o && !stalled |-> busy_cnt < 6'h10)
    else $error("transfer too long");
  chk_dma_clear: assert property (
    $fell(dma_busy_o) && !can_reset_request_i && sfr_addr_i == 8'hDB
    |-> !sfr_rdata_o[7])
    else $error("dma bit left set");
  chk_irq_hold: assert property (dma_start |-> ##[1:2] irq_block_o)
    else $error("interrupts not held off");
  chk_rr_block: assert property (
    can_reset_request_i [*2] |-> !ram_wr_o && !irq_block_o)
    else $error("transfer under reset request");
  chk_ptr_reset: assert property (
    $rose(nrst_i) && sfr_addr_i == 8'hDB |-> sfr_rdata_o == 8'h64)
    else $error("pointer reset value wrong");
endmodule // ccp_port_chk
bind ccp_port ccp_port_chk u_ccp_port_chk (.*);

// [tb/test_ccp_port.sv]
// Self-checking bench for ccp_port.
// Assumes ccp_partner serves the controller and RAM ports.
`timescale 1ns/10ps
module test_ccp_port;
  logic clk_sys_i, nrst_i, sfr_rd_i, sfr_wr_i, sfr_bit_rd_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, sfr_bit_addr_i, rv;
  logic [7:0] can_wdata_o, can_rdata_i, can_cmd_o, can_status_i;
  logic [7:0] ram_addr_o, ram_wdata_o, ram_rdata_i;
  logic [4:0] can_addr_o, can_irq_flags_i;
  logic sfr_bit_rdata_o, can_rd_o, can_wr_o, can_cmd_wr_o, ram_rd_o;
  logic can_reset_request_i, can_ready_i, ram_wr_o, irq_block_o;
  logic dma_busy_o;
  int num_errors, n_checks;
  ccp_port u_ccp_port (.*);
  ccp_partner u_ccp_partner (.clk_sys_i(clk_sys_i),
    .can_rd_i(can_rd_o), .can_wr_i(can_wr_o), .can_ready_i(can_ready_i),
    .can_cmd_wr_i(can_cmd_wr_o), .ram_rd_i(ram_rd_o), .ram_wr_i(ram_wr_o),
    .can_addr_i(can_addr_o), .can_wdata_i(can_wdata_o),
    .can_cmd_i(can_cmd_o), .ram_addr_i(ram_addr_o),
    .ram_wdata_i(ram_wdata_o), .can_rdata_o(can_rdata_i),
    .ram_rdata_o(ram_rdata_i));
  // ==========
  // Bus cycles and comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge clk_sys_i);
    rv = sfr_rdata_o;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
  endtask
  // Wait out a transfer without touching the port, optionally stalling
  task automatic dma_wait(input int stall);
    for (int k = 0; k < 40 && dma_busy_o !== 1'b0; k++) begin
      @(negedge clk_sys_i);
      can_ready_i = !(stall != 0 && k > 1 && k < 5);
    end
    chk({7'h00, dma_busy_o}, 8'h00);
  endtask
  // ==========
  // Scenarios
  task automatic t_pointer();
    rd(8'hDB);
    chk(rv, 8'h64);
    wr(8'hDB, 8'h3E);
    wr(8'hDA, 8'hC3);
    wr(8'hDA, 8'h3C);
    chk(u_ccp_partner.regs[30], 8'hC3);
    chk(u_ccp_partner.regs[31], 8'h3C);
    rd(8'hDB);
    chk(rv, 8'h00);
    wr(8'hDB, 8'h07);
    rd(8'hDA);
    chk(rv, 8'hA7);
  endtask
  task automatic t_cmd_status();
    logic [7:0] st;
    for (int i = 0; i < 8; i++) begin
      wr(8'hD9, 8'h01 << i);
      chk(u_ccp_partner.cmd, 8'h01 << i);
      st = (8'h01 << i) ^ 8'hA5;
      can_status_i = st;
      can_irq_flags_i = 5'h01 << (i % 5);
      rd(8'hD9);
      chk(rv, {3'h7, can_irq_flags_i});
      rd(8'hD8);
      chk(rv, st);
      sfr_bit_addr_i = 8'hD8 + 8'(i);
      sfr_bit_rd_i = 1'b1;
      @(posedge clk_sys_i);
      chk({7'h00, sfr_bit_rdata_o}, {7'h00, st[i]});
    end
  endtask
  task automatic t_tx_dma();
    wr(8'hD8, 8'h40);
    wr(8'hDB, 8'h8A);
    chk({7'h00, dma_busy_o}, 8'h01);
    dma_wait(1);
    for (int i = 0; i < 10; i++)
      chk(u_ccp_partner.regs[10 + i], 8'(8'h40 + i) ^ 8'h5A);
    chk(u_ccp_partner.regs[20], 8'hB4);
    rd(8'hDB);
    chk({7'h00, rv[7]}, 8'h00);
  endtask
  task automatic t_rx_dma();
    wr(8'hD8, 8'h80);
    wr(8'hDB, 8'h96);
    dma_wait(0);
    for (int i = 0; i < 5; i++)
      chk(u_ccp_partner.mem[8'h80 + i], 8'hB6 + 8'(i));
    chk(u_ccp_partner.mem[8'h85], 8'hDF);
  endtask
  task automatic t_refuse();
    can_reset_request_i = 1'b1;
    wr(8'hD8, 8'h90);
    wr(8'hDB, 8'h8A);
    repeat (4) @(posedge clk_sys_i);
    chk({7'h00, dma_busy_o}, 8'h00);
    chk(u_ccp_partner.regs[10], 8'h1A);
    @(negedge clk_sys_i);
    can_reset_request_i = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Clock, watchdog and main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
  initial begin
    nrst_i = 1'b0;
    sfr_addr_i = 8'hDB;
    {sfr_rd_i, sfr_wr_i, sfr_bit_rd_i, can_reset_request_i} = 4'h0;
    {sfr_wdata_i, sfr_bit_addr_i, can_status_i} = 24'h000000;
    can_irq_flags_i = 5'h00;
    can_ready_i = 1'b1;
    repeat (16) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    t_pointer();
    t_cmd_status();
    t_tx_dma();
    t_rx_dma();
    t_refuse();
    close_out();
  end
endmodule // test_ccp_port
